/* core/pgct_colormem.sv */
/*
 * pgct_colormem: sixteen color bytes with reset values, one write port,
 * two read ports whose data come out of registers and hold when not enabled.
 * Assumes one clock; slot 15 never written by the caller.
 */
`timescale 1ns/1ps
`default_nettype none
module pgct_colormem (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // write port
   input  wire logic       we,
   input  wire logic [3:0] waddr,
   input  wire logic [7:0] wdata,
   // bus read port
   input  wire logic       bus_re,
   input  wire logic [3:0] bus_addr,
   output logic [7:0]      bus_rdata,
   // pattern read port
   input  wire logic       pat_re,
   input  wire logic [3:0] pat_addr,
   output logic [7:0]      pat_rdata
);
   logic [7:0] slot_reg  [16];
   logic [7:0] slot_next [16];
   logic [7:0] bus_next;
   logic [7:0] pat_next;

   always_comb begin
      for (int i = 0; i < 16; i++) begin
         slot_next[i] = (we && waddr == 4'(i)) ? wdata : slot_reg[i];
      end
      bus_next = bus_re ? slot_reg[bus_addr] : bus_rdata;
      pat_next = pat_re ? slot_reg[pat_addr] : pat_rdata;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            slot_reg[i] <= pgct_pkg::COLOR_RST[i];
         end
         bus_rdata <= 8'h00;
         pat_rdata <= 8'h00;
      end else begin
         slot_reg  <= slot_next;
         bus_rdata <= bus_next;
         pat_rdata <= pat_next;
      end
   end
endmodule : pgct_colormem
`default_nettype wire

/* core/pgct_fifo.sv */
/*
 * pgct_fifo: synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; depth is a power of two.
 */
`timescale 1ns/1ps
`default_nettype none
module pgct_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic                     mclk,
   input  wire logic                     rst,
   // fill side
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   // drain side
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [WIDTH-1:0]              out_data,
   // fill level
   output logic [$clog2(DEPTH):0]        count
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0]      wptr_reg;
   logic [AW:0]      rptr_reg;
   logic [AW:0]      wptr_next;
   logic [AW:0]      rptr_next;
   logic             push;
   logic             pop;

   always_comb begin
      count     = wptr_reg - rptr_reg;
      in_ready  = (count != DEPTH[AW:0]);
      out_valid = (count != '0);
      out_data  = mem_reg[rptr_reg[AW-1:0]];
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
      rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
      end else begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem_reg[wptr_reg[AW-1:0]] <= in_data;
      end
   end
endmodule : pgct_fifo
`default_nettype wire

/* core/pgct_pkg.sv */
/*
 * pgct_pkg: constants for the pattern generator color table.
 * Assumes byte-wide color registers reached as word slots over AHB-Lite.
 */
package pgct_pkg;

   localparam int unsigned DATA_W     = 8;
   localparam int unsigned FIFO_W     = 9;
   localparam int unsigned FIFO_DEPTH = 8;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_COLOR0   = 6'h10;
   localparam logic [5:0] IDX_COLOR1   = 6'h11;
   localparam logic [5:0] IDX_COLOR2   = 6'h12;
   localparam logic [5:0] IDX_BAR3     = 6'h13;
   localparam logic [5:0] IDX_BAR4     = 6'h14;
   localparam logic [5:0] IDX_BAR5     = 6'h15;
   localparam logic [5:0] IDX_BAR6     = 6'h16;
   localparam logic [5:0] IDX_BAR7     = 6'h17;
   localparam logic [5:0] IDX_FIXED9   = 6'h18;
   localparam logic [5:0] IDX_FIXED10  = 6'h19;
   localparam logic [5:0] IDX_FIXED11  = 6'h1a;
   localparam logic [5:0] IDX_FIXED12  = 6'h1b;
   localparam logic [5:0] IDX_FIXED13  = 6'h1c;
   localparam logic [5:0] IDX_FIXED14  = 6'h1d;
   localparam logic [5:0] IDX_FIXED15  = 6'h1e;
   localparam logic [5:0] IDX_RESERVED = 6'h1f;
   localparam logic [5:0] IDX_CTRL     = 6'h20;
   localparam logic [5:0] IDX_BARW     = 6'h21;
   localparam logic [5:0] IDX_LINELEN  = 6'h22;
   localparam logic [5:0] IDX_STATUS   = 6'h23;

   // control fields
   localparam int unsigned CTRL_RUN_BIT   = 0;
   localparam int unsigned CTRL_FIXED_BIT = 1;
   localparam logic [1:0]  CTRL_RST       = 2'h0;
   localparam logic [15:0] BARW_RST       = 16'h0004;
   localparam logic [15:0] LINELEN_RST    = 16'h0010;

   // pattern sequencing
   localparam logic [3:0] LAST_BAR   = 4'h7;
   localparam logic [3:0] LAST_FIXED = 4'he;

   // reset bytes of table slots 0..15
   localparam logic [7:0] COLOR_RST [0:15] = '{
      8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   typedef enum logic [1:0] {
      PGCT_BUS_IDLE,
      PGCT_BUS_RD1,
      PGCT_BUS_RD2
   } pgct_bus_t;

   function automatic logic [3:0] wrap_inc(input logic [3:0] i, input logic [3:0] last);
      wrap_inc = (i == last) ? 4'h0 : i + 4'h1;
   endfunction : wrap_inc

   function automatic logic is_table(input logic [5:0] idx);
      is_table = (idx >= IDX_COLOR0) && (idx <= IDX_FIXED15);
   endfunction : is_table

endpackage : pgct_pkg

/* core/pgct_top.sv */
/*
 * pgct_top: pattern generator color table with its byte sequencer.
 * Holds the color bytes behind an AHB-Lite slave and streams the
 * color-bar or fixed-color pattern through an 8-word FIFO.
 * Assumes a single AHB master, word transfers only, and a downstream
 * consumer on mclk using valid/ready.
 */
// Functional notes
// - in color-bar mode bar 3 carries the bar3_byte value, and in fixed mode it is pattern byte four.
// - in color-bar mode bar 4 carries the bar4_byte value, and in fixed mode it is pattern byte five.
// - in color-bar mode bar 5 carries the bar5_byte value, and in fixed mode it is pattern byte six.
// - in color-bar mode bar 6 carries the bar6_byte value, and in fixed mode it is pattern byte seven.
// - in color-bar mode bar 7, the last bar, carries bar7_byte, and in fixed mode it is pattern byte eight.
// - fixed_byte_9 and fixed_byte_10 feed pattern bytes nine and ten in fixed mode only.
// - fixed_byte_11 to fixed_byte_15 feed pattern bytes eleven to fifteen in order in fixed mode.
// - bar bytes 3 to 7 reset to 7f, 55, cc, 0f, 80 and fixed bytes 9 and 10 reset to zero.
// - bars 0 to 2 and fixed bytes one to three come from slots 0x10 to 0x12, reset aa, 33, f0.
`timescale 1ns/1ps
`default_nettype none
module pgct_top (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   // pattern byte stream
   output logic [7:0]       pix_data,
   output logic             pix_valid,
   output logic             pix_last,
   input  wire logic        pix_ready
);
   // bus slave state
   pgct_pkg::pgct_bus_t bus_reg, bus_next;
   logic        wr_pend_reg, wr_pend_next;
   logic [5:0]  idx_reg, idx_next;
   logic        hready_reg, hready_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic        accept;
   logic        bus_re;
   logic        mem_we;
   // control registers
   logic [1:0]  ctrl_reg, ctrl_next;
   logic [15:0] barw_reg, barw_next;
   logic [15:0] linelen_reg, linelen_next;
   logic        run;
   logic        fixed_mode;
   // sequencer
   logic [3:0]  seq_idx_reg, seq_idx_next;
   logic [15:0] byte_cnt_reg, byte_cnt_next;
   logic [15:0] line_cnt_reg, line_cnt_next;
   logic        pend_reg, pend_next;
   logic [3:0]  pend_idx_reg, pend_idx_next;
   logic        pend_last_reg, pend_last_next;
   logic        pend_fixed_reg, pend_fixed_next;
   logic        adv;
   logic        seg_end;
   logic        line_end;
   logic [3:0]  pat_addr;
   // memory and fifo wiring
   logic [7:0]  mem_bus_rdata;
   logic [7:0]  mem_pat_rdata;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [8:0]  fifo_out_data;
   logic [3:0]  fifo_count;
   // output stage
   logic [7:0]  pix_data_reg, pix_data_next;
   logic        pix_valid_reg, pix_valid_next;
   logic        pix_last_reg, pix_last_next;

   // ---------------- bus slave
   always_comb begin
      accept       = hsel && hready && htrans[1];
      bus_next     = bus_reg;
      wr_pend_next = 1'b0;
      idx_next     = idx_reg;
      hready_next  = hready_reg;
      hrdata_next  = hrdata_reg;
      bus_re       = 1'b0;
      case (bus_reg)
         pgct_pkg::PGCT_BUS_IDLE: begin
            if (accept) begin
               idx_next = (haddr[31:8] == 24'h000000) ? haddr[7:2] : 6'h3f;
               if (hwrite) begin
                  wr_pend_next = 1'b1;
               end else begin
                  bus_next    = pgct_pkg::PGCT_BUS_RD1;
                  hready_next = 1'b0;
               end
            end
         end
         pgct_pkg::PGCT_BUS_RD1: begin
            bus_re   = 1'b1;
            bus_next = pgct_pkg::PGCT_BUS_RD2;
         end
         pgct_pkg::PGCT_BUS_RD2: begin
            if (pgct_pkg::is_table(idx_reg)) begin
               hrdata_next = {24'h000000, mem_bus_rdata};
            end else begin
               case (idx_reg)
                  pgct_pkg::IDX_CTRL:    hrdata_next = {30'h00000000, ctrl_reg};
                  pgct_pkg::IDX_BARW:    hrdata_next = {16'h0000, barw_reg};
                  pgct_pkg::IDX_LINELEN: hrdata_next = {16'h0000, linelen_reg};
                  pgct_pkg::IDX_STATUS:  hrdata_next = {26'h0000000, pend_reg, run, fifo_count};
                  default:               hrdata_next = 32'h00000000;
               endcase
            end
            hready_next = 1'b1;
            bus_next    = pgct_pkg::PGCT_BUS_IDLE;
         end
         default: begin
            bus_next    = pgct_pkg::PGCT_BUS_IDLE;
            hready_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_reg     <= pgct_pkg::PGCT_BUS_IDLE;
         wr_pend_reg <= 1'b0;
         idx_reg     <= 6'h00;
         hready_reg  <= 1'b1;
         hrdata_reg  <= 32'h00000000;
      end else begin
         bus_reg     <= bus_next;
         wr_pend_reg <= wr_pend_next;
         idx_reg     <= idx_next;
         hready_reg  <= hready_next;
         hrdata_reg  <= hrdata_next;
      end
   end

   // ---------------- control registers; reserved slot drops writes
   always_comb begin
      mem_we       = wr_pend_reg && pgct_pkg::is_table(idx_reg);
      ctrl_next    = ctrl_reg;
      barw_next    = barw_reg;
      linelen_next = linelen_reg;
      if (wr_pend_reg) begin
         case (idx_reg)
            pgct_pkg::IDX_CTRL:    ctrl_next    = hwdata[1:0];
            pgct_pkg::IDX_BARW:    barw_next    = hwdata[15:0];
            pgct_pkg::IDX_LINELEN: linelen_next = hwdata[15:0];
            default:               ctrl_next    = ctrl_reg;
         endcase
      end
      run        = ctrl_reg[pgct_pkg::CTRL_RUN_BIT];
      fixed_mode = ctrl_reg[pgct_pkg::CTRL_FIXED_BIT];
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg    <= pgct_pkg::CTRL_RST;
         barw_reg    <= pgct_pkg::BARW_RST;
         linelen_reg <= pgct_pkg::LINELEN_RST;
      end else begin
         ctrl_reg    <= ctrl_next;
         barw_reg    <= barw_next;
         linelen_reg <= linelen_next;
      end
   end

   pgct_colormem u_mem (
      .mclk      (mclk),
      .rst       (rst),
      .we        (mem_we),
      .waddr     (idx_reg[3:0]),
      .wdata     (hwdata[7:0]),
      .bus_re    (bus_re),
      .bus_addr  (idx_reg[3:0]),
      .bus_rdata (mem_bus_rdata),
      .pat_re    (adv),
      .pat_addr  (pat_addr),
      .pat_rdata (mem_pat_rdata)
   );

   // ---------------- byte sequencer; one table read per byte
   always_comb begin
      adv      = run && (!pend_reg || fifo_in_ready);
      seg_end  = (byte_cnt_reg >= barw_reg - 16'h0001) || (barw_reg == 16'h0000);
      line_end = (line_cnt_reg >= linelen_reg - 16'h0001) || (linelen_reg == 16'h0000);
      // bar mode only ever reaches slots 0..7
      pat_addr = fixed_mode ? seq_idx_reg : {1'b0, seq_idx_reg[2:0]};
      seq_idx_next    = seq_idx_reg;
      byte_cnt_next   = byte_cnt_reg;
      line_cnt_next   = line_cnt_reg;
      pend_idx_next   = pend_idx_reg;
      pend_last_next  = pend_last_reg;
      pend_fixed_next = pend_fixed_reg;
      pend_next       = (pend_reg && !fifo_in_ready);
      if (!run) begin
         seq_idx_next  = 4'h0;
         byte_cnt_next = 16'h0000;
         line_cnt_next = 16'h0000;
      end else if (adv) begin
         pend_next       = 1'b1;
         pend_idx_next   = pat_addr;
         pend_fixed_next = fixed_mode;
         if (fixed_mode) begin
            pend_last_next = line_end;
            if (line_end) begin
               line_cnt_next = 16'h0000;
               seq_idx_next  = 4'h0;
            end else begin
               line_cnt_next = line_cnt_reg + 16'h0001;
               seq_idx_next  = pgct_pkg::wrap_inc(seq_idx_reg, pgct_pkg::LAST_FIXED);
            end
         end else begin
            pend_last_next = seg_end && (seq_idx_reg[2:0] == pgct_pkg::LAST_BAR[2:0]);
            if (seg_end) begin
               byte_cnt_next = 16'h0000;
               seq_idx_next  = pgct_pkg::wrap_inc({1'b0, seq_idx_reg[2:0]}, pgct_pkg::LAST_BAR);
            end else begin
               byte_cnt_next = byte_cnt_reg + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seq_idx_reg    <= 4'h0;
         byte_cnt_reg   <= 16'h0000;
         line_cnt_reg   <= 16'h0000;
         pend_reg       <= 1'b0;
         pend_idx_reg   <= 4'h0;
         pend_last_reg  <= 1'b0;
         pend_fixed_reg <= 1'b0;
      end else begin
         seq_idx_reg    <= seq_idx_next;
         byte_cnt_reg   <= byte_cnt_next;
         line_cnt_reg   <= line_cnt_next;
         pend_reg       <= pend_next;
         pend_idx_reg   <= pend_idx_next;
         pend_last_reg  <= pend_last_next;
         pend_fixed_reg <= pend_fixed_next;
      end
   end

   pgct_fifo #(
      .WIDTH (pgct_pkg::FIFO_W),
      .DEPTH (pgct_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst       (rst),
      .in_valid  (pend_reg),
      .in_ready  (fifo_in_ready),
      .in_data   ({pend_last_reg, mem_pat_rdata}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .count     (fifo_count)
   );

   // ---------------- registered output stage
   always_comb begin
      fifo_out_ready = !pix_valid_reg || pix_ready;
      pix_valid_next = pix_valid_reg && !pix_ready;
      pix_data_next  = pix_data_reg;
      pix_last_next  = pix_last_reg;
      if (fifo_out_ready && fifo_out_valid) begin
         pix_valid_next = 1'b1;
         pix_data_next  = fifo_out_data[7:0];
         pix_last_next  = fifo_out_data[8];
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pix_valid_reg <= 1'b0;
         pix_data_reg  <= 8'h00;
         pix_last_reg  <= 1'b0;
      end else begin
         pix_valid_reg <= pix_valid_next;
         pix_data_reg  <= pix_data_next;
         pix_last_reg  <= pix_last_next;
      end
   end

   assign hreadyout = hready_reg;
   assign hrdata    = hrdata_reg;
   assign hresp     = 1'b0;
   assign pix_data  = pix_data_reg;
   assign pix_valid = pix_valid_reg;
   assign pix_last  = pix_last_reg;

   // ---------------- checks
   logic untouched_reg;
   logic push;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         untouched_reg <= 1'b1;
      end else if (mem_we) begin
         untouched_reg <= 1'b0;
      end
   end
   assign push = pend_reg && fifo_in_ready;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_bar3_value: assert property (push && untouched_reg && pend_idx_reg == 4'h3 |-> mem_pat_rdata == 8'h7f)
      else $error("bar 3 byte wrong");
   a_bar4_value: assert property (push && untouched_reg && pend_idx_reg == 4'h4 |-> mem_pat_rdata == 8'h55)
      else $error("bar 4 byte wrong");
   a_bar5_value: assert property (push && untouched_reg && pend_idx_reg == 4'h5 |-> mem_pat_rdata == 8'hcc)
      else $error("bar 5 byte wrong");
   a_bar6_value: assert property (push && untouched_reg && pend_idx_reg == 4'h6 |-> mem_pat_rdata == 8'h0f)
      else $error("bar 6 byte wrong");
   a_bar7_last: assert property (push && !pend_fixed_reg && pend_last_reg |-> pend_idx_reg == 4'h7)
      else $error("line end not on bar 7");
   a_bar_range: assert property (pend_reg && !pend_fixed_reg |-> pend_idx_reg <= 4'h7)
      else $error("bar mode read a fixed-only slot");
   a_fixed_order: assert property (adv && fixed_mode && !line_end && seq_idx_reg < 4'he
                                   |=> pend_reg && seq_idx_reg == $past(seq_idx_reg) + 4'h1)
      else $error("fixed byte order broken");
   a_reset_table: assert property (push && untouched_reg
                                   |-> mem_pat_rdata == pgct_pkg::COLOR_RST[pend_idx_reg])
      else $error("table reset value wrong");
   a_low_bars: assert property (push && untouched_reg && pend_idx_reg < 4'h3
                                |-> mem_pat_rdata inside {8'haa, 8'h33, 8'hf0})
      else $error("low bar byte wrong");
   a_line_restart: assert property (adv && fixed_mode && line_end |=> seq_idx_reg == 4'h0 ##1 1'b1)
      else $error("fixed pattern did not restart");
   a_read_wait: assert property (bus_reg == pgct_pkg::PGCT_BUS_RD1 |-> !hreadyout ##1 !hreadyout ##1 hreadyout)
      else $error("read wait states wrong");

   c_bar_line: cover property (push && !pend_fixed_reg && pend_last_reg);
   c_fixed_wrap: cover property (push && pend_fixed_reg && pend_idx_reg == 4'he);
   c_fifo_full: cover property (run && !fifo_in_ready);
   c_bus_read: cover property (bus_reg == pgct_pkg::PGCT_BUS_RD2);
endmodule : pgct_top
`default_nettype wire

/* verification/pgct_sink.sv */
/*
 * pgct_sink: behavioural model of the downstream byte consumer.
 * Assumes the same clock as the pattern stream; stall stops it taking bytes.
 */
`timescale 1ns/1ps
`default_nettype none
module pgct_sink (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // pattern byte stream
   input  wire logic [7:0] pix_data,
   input  wire logic       pix_valid,
   input  wire logic       pix_last,
   output logic            pix_ready,
   // pacing from the bench
   input  wire logic       stall
);
   logic [8:0] q [$];

   assign pix_ready = !stall;

   // record every byte taken, with its end-of-line mark
   always @(posedge mclk) begin
      if (!rst && pix_valid && pix_ready) begin
         q.push_back({pix_last, pix_data});
      end
   end
endmodule : pgct_sink
`default_nettype wire

/* verification/tb_top.sv */
/*
 * tb_top: self-checking bench for pgct_top.
 * Assumes an AHB-Lite master in the bench and pgct_sink as consumer.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [7:0]  pix_data;
   logic        pix_valid;
   logic        pix_last;
   logic        pix_ready;
   logic        stall = 1'b0;
   logic [31:0] rd;
   int          mismatches = 0;
   int          checks_done = 0;
   logic [7:0]  rst_tbl [0:15] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80,
                                   8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]  exp_tbl [0:15];

   always #10 mclk = ~mclk;

   pgct_top dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pix_data(pix_data),
      .pix_valid(pix_valid), .pix_last(pix_last), .pix_ready(pix_ready));

   pgct_sink sink (.mclk(mclk), .rst(rst), .pix_data(pix_data), .pix_valid(pix_valid),
      .pix_last(pix_last), .pix_ready(pix_ready), .stall(stall));

   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   // one single transfer; entered just after a rising edge
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(32'h0, {31'h0, hresp});
   endtask : ahb

   task automatic wait_bytes(input int n);
      while (sink.q.size() < n) begin
         @(posedge mclk);
      end
   endtask : wait_bytes

   task automatic t_reset_vals;
      for (int i = 0; i < 16; i++) begin
         ahb(1'b0, 32'h40 + 4 * i, 32'h0);
         chk({24'h0, rst_tbl[i]}, rd);
      end
   endtask : t_reset_vals

   task automatic t_table_rw;
      for (int i = 0; i < 15; i++) begin
         exp_tbl[i] = {i[3:0], ~i[3:0]};
         ahb(1'b1, 32'h40 + 4 * i, {24'h0, exp_tbl[i]});
         ahb(1'b0, 32'h40 + 4 * i, 32'h0);
         chk({24'h0, exp_tbl[i]}, rd);
      end
      ahb(1'b1, 32'h7c, 32'hff);
      ahb(1'b0, 32'h7c, 32'h0);
      chk(32'h0, rd);
      ahb(1'b0, 32'h100, 32'h0);
      chk(32'h0, rd);
   endtask : t_table_rw

   // bar mode, one byte per bar, consumer stalled until the fifo is full
   task automatic t_bar_stall;
      ahb(1'b1, 32'h84, 32'h1);
      stall <= 1'b1;
      ahb(1'b1, 32'h80, 32'h1);
      repeat (30) @(posedge mclk);
      ahb(1'b0, 32'h8c, 32'h0);
      chk(32'h38, rd);
      stall <= 1'b0;
      wait_bytes(9);
      for (int i = 0; i < 9; i++) begin
         chk({23'h0, i == 7, rst_tbl[i % 8]}, {23'h0, sink.q[i]});
      end
      ahb(1'b1, 32'h80, 32'h0);
      repeat (40) @(posedge mclk);
      ahb(1'b0, 32'h8c, 32'h0);
      chk(32'h0, rd);
      sink.q.delete();
   endtask : t_bar_stall

   // fixed mode, a 17-byte line wraps past the fifteenth byte
   task automatic t_fixed;
      ahb(1'b1, 32'h88, 32'h11);
      ahb(1'b1, 32'h80, 32'h3);
      wait_bytes(18);
      for (int j = 0; j < 18; j++) begin
         chk({23'h0, j == 16, exp_tbl[(j % 17) % 15]}, {23'h0, sink.q[j]});
      end
      ahb(1'b1, 32'h80, 32'h0);
   endtask : t_fixed

   task automatic wrap_up;
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end

   initial begin
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      t_reset_vals();
      t_bar_stall();
      t_table_rw();
      t_fixed();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
